/* File: logic/ccfg_map.vh */
`ifndef CCFG_MAP_VH
`define CCFG_MAP_VH
// ****************************************
// Register addresses
// ****************************************
`define CCFG_A_NOISE    8'h5d
`define CCFG_A_CLKPOS   8'h62
`define CCFG_A_PFR      8'h63
`define CCFG_A_PAT      8'h65
`define CCFG_A_GAIN     8'h68
`define CCFG_A_CUST_LO  8'h69
`define CCFG_A_CUST_HI  8'h6a
`define CCFG_A_OIF      8'h6c
`define CCFG_A_REF      8'h6d
`define CCFG_A_SRST     8'h6e
// ****************************************
// Field positions
// ****************************************
`define CCFG_B_NOISE    0
`define CCFG_F_CLKPOS   4:0
`define CCFG_B_PD       7
`define CCFG_B_FMT      3
`define CCFG_B_LOWSPD   0
`define CCFG_F_PAT      7:5
`define CCFG_F_GAIN     3:0
`define CCFG_B_GAIN_EN  3
`define CCFG_F_GAIN_DB  2:0
`define CCFG_F_OIF      4:3
`define CCFG_B_REF      4
`define CCFG_B_SRST     0
`define CCFG_B_MSB      15
// ****************************************
// Reset values
// ****************************************
`define CCFG_R_CLKPOS   5'h00
`define CCFG_R_GAIN     4'h9
`define CCFG_R_OIF      2'h0
`define CCFG_R_PAT      3'h0
`define CCFG_R_BYTE     8'h00
// ****************************************
// Codes
// ****************************************
`define CCFG_PAT_NORM   3'h0
`define CCFG_PAT_ZERO   3'h1
`define CCFG_PAT_ONES   3'h2
`define CCFG_PAT_TOG    3'h3
`define CCFG_PAT_RAMP   3'h4
`define CCFG_PAT_CUST   3'h5
`define CCFG_OIF_LVDS   2'h1
`define CCFG_OIF_CMOS   2'h3
`define CCFG_TOG_A      16'haaaa
`define CCFG_TOG_B      16'h5555
`define CCFG_ALL0       16'h0000
`define CCFG_ALL1       16'hffff
`define CCFG_GAIN_1DB   3'h1
// ****************************************
// Clock position shifts, in 36ths of a sample period
// ****************************************
`define CCFG_SH_NONE    5'sd0
`define CCFG_SH_M3      -5'sd3
`define CCFG_SH_P3      5'sd3
`define CCFG_SH_P5      5'sd5
`define CCFG_SH_P6      5'sd6
`define CCFG_SH_P7      5'sd7
`define CCFG_FRAC_DEN   13'sd36
`define CCFG_CNT_MAX    8'hff
`endif

/* File: logic/ccfg_sync.v */
`timescale 1ns/1ps
// ****************************************
// Two-stage synchroniser for pins
// ****************************************
module ccfg_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rst_n_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] meta;

  // First stage feeds only the second
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta <= {W{1'b0}};
      q_o  <= {W{1'b0}};
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule // ccfg_sync

/* File: logic/ccfg_patgen.v */
`timescale 1ns/1ps
`include "ccfg_map.vh"
// ****************************************
// Output word source: samples or test pattern
// ****************************************
module ccfg_patgen (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        step_i,
  input  wire        blank_i,
  input  wire [2:0]  sel_i,
  input  wire        offs_bin_i,
  input  wire [15:0] cust_i,
  input  wire [15:0] sample_i,
  output reg  [15:0] data_o
);
  reg [15:0] ramp;
  reg        tog;
  reg [15:0] next_data;

  // Word chosen for the next sample slot
  always @*
  begin
    next_data = sample_i;
    case (sel_i)
      `CCFG_PAT_NORM: next_data = {sample_i[`CCFG_B_MSB] ^ offs_bin_i,
                                   sample_i[`CCFG_B_MSB-1:0]};
      `CCFG_PAT_ZERO: next_data = `CCFG_ALL0;
      `CCFG_PAT_ONES: next_data = `CCFG_ALL1;
      `CCFG_PAT_TOG:  next_data = tog ? `CCFG_TOG_B : `CCFG_TOG_A;
      `CCFG_PAT_RAMP: next_data = ramp;
      `CCFG_PAT_CUST: next_data = cust_i;
      // Undefined codes fall back to live samples
      default:        next_data = {sample_i[`CCFG_B_MSB] ^ offs_bin_i,
                                   sample_i[`CCFG_B_MSB-1:0]};
    endcase
  end

  // Word register; buffers off in power-down
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      data_o <= `CCFG_ALL0;
      ramp   <= `CCFG_ALL0;
      tog    <= 1'b0;
    end
    else if (blank_i)
    begin
      data_o <= `CCFG_ALL0;
      ramp   <= `CCFG_ALL0;
      tog    <= 1'b0;
    end
    else if (step_i)
    begin
      data_o <= next_data;
      tog    <= ~tog;
      // Ramp wraps from all ones back to zero by plain overflow
      ramp   <= (sel_i == `CCFG_PAT_RAMP) ? ramp + 16'h0001 : `CCFG_ALL0;
    end
  end
endmodule // ccfg_patgen

/* File: logic/ccfg_top.v */
// Notes on behaviour
// - Noise cut bit enables suppression when set
// - Clock shift resets 00000; 00000/00001 default
// - CMOS rising edge shift by low code bits
// - LVDS falling edge delay by low bits
// - CMOS falling edge shift by high bits
// - LVDS rising edge delay by high bits
// - Format bit: two's complement or offset binary
// - Reduced rate bit selects low speed mode
// - Power-down stops core, references, output buffers
// - Pattern 000 samples, 001 zeros, 010 ones
// - Pattern 011 toggles per word and bit
// - Pattern 100 ramps one code per word
// - Pattern 101 drives custom sixteen-bit word
// - Low byte bits 7..0, high byte 15..8
// - Gain code 1000..1110 is 0..6 dB
// - Interface select: pin, forced LVDS, forced CMOS
// - Reference bit picks internal or external reference
// - Soft reset bit restores all defaults
`timescale 1ns/1ps
`include "ccfg_map.vh"
module ccfg_top (
  input  wire        sys_clk_i,
  input  wire        arst_n_i,
  input  wire        samp_clk_i,
  input  wire        format_select_pin_i,
  input  wire [15:0] conv_data_i,
  input  wire        reg_wr_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  output reg  [7:0]  reg_rdata_o,
  output reg  [15:0] data_o,
  output reg         out_clk_o,
  output reg         lvds_mode_o,
  output reg         low_band_noise_cut_o,
  output reg         low_speed_o,
  output reg         power_down_o,
  output reg         ext_ref_o,
  output reg  [2:0]  gain_db_o
);
  // ****************************************
  // Reset release
  // ****************************************
  reg        rst_m;
  reg        rst_n;

  // Async assert, synchronous release
  always @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end
  // ****************************************
  // Configuration registers
  // ****************************************
  reg        r_noise;
  reg [4:0]  r_clkpos;
  reg        r_pd;
  reg        r_fmt;
  reg        r_lowspd;
  reg [2:0]  r_pat;
  reg [3:0]  r_gain;
  reg [7:0]  r_cust_lo;
  reg [7:0]  r_cust_hi;
  reg [1:0]  r_oif;
  reg        r_ref;
  wire       soft_rst;

  assign soft_rst = reg_wr_i && (reg_addr_i == `CCFG_A_SRST)
                    && reg_wdata_i[`CCFG_B_SRST];

  // Only documented fields are stored; unused bits are dropped
  always @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_noise   <= 1'b0;
      r_clkpos  <= `CCFG_R_CLKPOS;
      r_pd      <= 1'b0;
      r_fmt     <= 1'b0;
      r_lowspd  <= 1'b0;
      r_pat     <= `CCFG_R_PAT;
      r_gain    <= `CCFG_R_GAIN;
      r_cust_lo <= `CCFG_R_BYTE;
      r_cust_hi <= `CCFG_R_BYTE;
      r_oif     <= `CCFG_R_OIF;
      r_ref     <= 1'b0;
    end
    else if (soft_rst)
    begin
      r_noise   <= 1'b0;
      r_clkpos  <= `CCFG_R_CLKPOS;
      r_pd      <= 1'b0;
      r_fmt     <= 1'b0;
      r_lowspd  <= 1'b0;
      r_pat     <= `CCFG_R_PAT;
      r_gain    <= `CCFG_R_GAIN;
      r_cust_lo <= `CCFG_R_BYTE;
      r_cust_hi <= `CCFG_R_BYTE;
      r_oif     <= `CCFG_R_OIF;
      r_ref     <= 1'b0;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `CCFG_A_NOISE:   r_noise  <= reg_wdata_i[`CCFG_B_NOISE];
        `CCFG_A_CLKPOS:  r_clkpos <= reg_wdata_i[`CCFG_F_CLKPOS];
        `CCFG_A_PFR:
        begin
          r_pd     <= reg_wdata_i[`CCFG_B_PD];
          r_fmt    <= reg_wdata_i[`CCFG_B_FMT];
          r_lowspd <= reg_wdata_i[`CCFG_B_LOWSPD];
        end
        `CCFG_A_PAT:     r_pat     <= reg_wdata_i[`CCFG_F_PAT];
        `CCFG_A_GAIN:    r_gain    <= reg_wdata_i[`CCFG_F_GAIN];
        `CCFG_A_CUST_LO: r_cust_lo <= reg_wdata_i;
        `CCFG_A_CUST_HI: r_cust_hi <= reg_wdata_i;
        `CCFG_A_OIF:     r_oif     <= reg_wdata_i[`CCFG_F_OIF];
        `CCFG_A_REF:     r_ref     <= reg_wdata_i[`CCFG_B_REF];
        default:         r_noise   <= r_noise;
      endcase
    end
  end
  // ****************************************
  // Read-back, one cycle after the address
  // ****************************************
  reg [7:0] next_rdata;

  // Unused bits read back as zero
  always @*
  begin
    next_rdata = `CCFG_R_BYTE;
    case (reg_addr_i)
      `CCFG_A_NOISE:   next_rdata[`CCFG_B_NOISE] = r_noise;
      `CCFG_A_CLKPOS:  next_rdata[`CCFG_F_CLKPOS] = r_clkpos;
      `CCFG_A_PFR:
      begin
        next_rdata[`CCFG_B_PD]     = r_pd;
        next_rdata[`CCFG_B_FMT]    = r_fmt;
        next_rdata[`CCFG_B_LOWSPD] = r_lowspd;
      end
      `CCFG_A_PAT:     next_rdata[`CCFG_F_PAT] = r_pat;
      `CCFG_A_GAIN:    next_rdata[`CCFG_F_GAIN] = r_gain;
      `CCFG_A_CUST_LO: next_rdata = r_cust_lo;
      `CCFG_A_CUST_HI: next_rdata = r_cust_hi;
      `CCFG_A_OIF:     next_rdata[`CCFG_F_OIF] = r_oif;
      `CCFG_A_REF:     next_rdata[`CCFG_B_REF] = r_ref;
      default:         next_rdata = `CCFG_R_BYTE;
    endcase
  end

  always @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_o <= `CCFG_R_BYTE;
    else
      reg_rdata_o <= next_rdata;
  end
  // ****************************************
  // Sample clock and format pin sampling
  // ****************************************
  wire [1:0] pins_s;
  reg        samp_d;
  wire       samp_rise;

  ccfg_sync #(
    .W (2)
  ) u_sync (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_n),
    .d_i     ({format_select_pin_i, samp_clk_i}),
    .q_o     (pins_s)
  );

  always @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      samp_d <= 1'b0;
    else
      samp_d <= pins_s[0];
  end

  // Each sample clock rise opens one output word
  assign samp_rise = pins_s[0] & ~samp_d;
  // ****************************************
  // Word-boundary shadow of settings
  // ****************************************
  reg [4:0]  sh_clkpos;
  reg [2:0]  sh_pat;
  reg        sh_fmt;
  reg        sh_lvds;
  reg        sh_pd;
  reg [15:0] sh_cust;
  reg [7:0]  cnt;
  reg [7:0]  per;
  wire       lvds_now;

  // Pin decides unless software forces a type; code 10 also follows the pin
  assign lvds_now = (r_oif == `CCFG_OIF_LVDS) ? 1'b1 :
                    (r_oif == `CCFG_OIF_CMOS) ? 1'b0 : pins_s[1];

  // Latched only at a word start so the output clock never glitches
  always @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_clkpos <= `CCFG_R_CLKPOS;
      sh_pat    <= `CCFG_R_PAT;
      sh_fmt    <= 1'b0;
      sh_lvds   <= 1'b0;
      sh_pd     <= 1'b0;
      sh_cust   <= `CCFG_ALL0;
      cnt       <= `CCFG_R_BYTE;
      per       <= `CCFG_CNT_MAX;
    end
    else if (samp_rise)
    begin
      sh_clkpos <= r_clkpos;
      sh_pat    <= r_pat;
      sh_fmt    <= r_fmt;
      sh_lvds   <= lvds_now;
      sh_pd     <= r_pd;
      sh_cust   <= {r_cust_hi, r_cust_lo};
      cnt       <= `CCFG_R_BYTE;
      per       <= cnt + 8'h01;
    end
    else if (cnt != `CCFG_CNT_MAX)
      cnt <= cnt + 8'h01;
  end
  // ****************************************
  // Output clock edge placement
  // ****************************************
  reg signed [4:0] rise_adj;
  reg signed [4:0] fall_adj;
  wire             pos_dflt;

  assign pos_dflt = ~sh_clkpos[0] | (sh_clkpos[4:1] == 4'h0);

  // Low code bits move one edge, high bits the other
  always @*
  begin
    rise_adj = `CCFG_SH_NONE;
    fall_adj = `CCFG_SH_NONE;
    if (!pos_dflt)
    begin
      if (!sh_lvds)
      begin
        case (sh_clkpos[2:1])
          2'h1:    rise_adj = `CCFG_SH_M3;
          2'h2:    rise_adj = `CCFG_SH_P3;
          2'h3:    rise_adj = `CCFG_SH_P5;
          default: rise_adj = `CCFG_SH_NONE;
        endcase
        case (sh_clkpos[4:3])
          2'h1:    fall_adj = `CCFG_SH_M3;
          2'h2:    fall_adj = `CCFG_SH_P3;
          2'h3:    fall_adj = `CCFG_SH_P5;
          default: fall_adj = `CCFG_SH_NONE;
        endcase
      end
      else
      begin
        case (sh_clkpos[2:1])
          2'h1:    fall_adj = `CCFG_SH_P3;
          2'h2:    fall_adj = `CCFG_SH_P6;
          2'h3:    fall_adj = `CCFG_SH_P6;
          default: fall_adj = `CCFG_SH_NONE;
        endcase
        case (sh_clkpos[4:3])
          2'h1:    rise_adj = `CCFG_SH_P3;
          2'h2:    rise_adj = `CCFG_SH_P7;
          2'h3:    rise_adj = `CCFG_SH_P7;
          default: rise_adj = `CCFG_SH_NONE;
        endcase
      end
    end
  end
  // Base slot plus shift, folded back into one sample period
  function [7:0] ccfg_place;
    input        [7:0] base;
    input signed [4:0] adj;
    input        [7:0] n;
    reg signed [12:0] t;
    begin
      t = $signed({5'h00, base})
          + ($signed(adj) * $signed({5'h00, n})) / `CCFG_FRAC_DEN;
      if (t < 13'sd0)
        t = t + $signed({5'h00, n});
      else if (t >= $signed({5'h00, n}))
        t = t - $signed({5'h00, n});
      ccfg_place = t[7:0];
    end
  endfunction
  wire [7:0] rise_pos;
  wire [7:0] fall_pos;

  // Default: falls with the word change, rises mid-word
  // Resolution is one system clock, so small shifts may round to zero
  assign rise_pos = ccfg_place({1'b0, per[7:1]}, rise_adj, per);
  assign fall_pos = ccfg_place(`CCFG_R_BYTE, fall_adj, per);
  // Output clock, held low while powered down
  always @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      out_clk_o <= 1'b0;
    else if (sh_pd)
      out_clk_o <= 1'b0;
    else if (cnt == rise_pos)
      out_clk_o <= 1'b1;
    else if (cnt == fall_pos)
      out_clk_o <= 1'b0;
  end
  // ****************************************
  // Data word path
  // ****************************************
  wire [15:0] word;

  ccfg_patgen u_pat (
    .clk_i      (sys_clk_i),
    .rst_n_i    (rst_n),
    .step_i     (cnt == `CCFG_R_BYTE),
    .blank_i    (sh_pd),
    .sel_i      (sh_pat),
    .offs_bin_i (sh_fmt),
    .cust_i     (sh_cust),
    .sample_i   (conv_data_i),
    .data_o     (word)
  );

  always @*
    data_o = word;
  // ****************************************
  // Analog control levels
  // ****************************************
  always @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_band_noise_cut_o <= 1'b0;
      low_speed_o          <= 1'b0;
      power_down_o         <= 1'b0;
      ext_ref_o            <= 1'b0;
      lvds_mode_o          <= 1'b0;
      gain_db_o            <= `CCFG_GAIN_1DB;
    end
    else
    begin
      low_band_noise_cut_o <= r_noise;
      low_speed_o          <= r_lowspd;
      power_down_o         <= r_pd;
      ext_ref_o            <= r_ref;
      lvds_mode_o          <= sh_lvds;
      // Top bit clear means 1 dB; else low bits give dB directly
      gain_db_o            <= r_gain[`CCFG_B_GAIN_EN] ?
                              r_gain[`CCFG_F_GAIN_DB] : `CCFG_GAIN_1DB;
    end
  end
endmodule // ccfg_top

/* File: testbench/ccfg_top_props.sv */
`timescale 1ns/1ps
// ****************************************
// Port checker for the configuration block
// ****************************************
module ccfg_top_props (
  input wire        sys_clk_i,
  input wire        arst_n_i,
  input wire        format_select_pin_i,
  input wire [15:0] conv_data_i,
  input wire        reg_wr_i,
  input wire [7:0]  reg_addr_i,
  input wire [7:0]  reg_wdata_i,
  input wire [15:0] data_o,
  input wire        out_clk_o,
  input wire        lvds_mode_o,
  input wire        low_band_noise_cut_o,
  input wire        low_speed_o,
  input wire        power_down_o,
  input wire        ext_ref_o,
  input wire [2:0]  gain_db_o
);
  reg  [7:0]  sh [0:17];
  reg  [4:0]  qcnt;
  reg  [3:0]  hcnt;
  reg         pin_q;
  reg  [15:0] conv_q;
  integer     i;
  wire [2:0]  pat = sh[8][7:5];
  wire [4:0]  ck = sh[5][4:0];
  wire        pd = sh[6][7];
  wire [1:0]  oif = sh[15][4:3];
  wire        lv = (oif == 2'h1) | ((oif != 2'h3) & pin_q);
  wire [2:0]  g_exp = sh[11][3] ? sh[11][2:0] : 3'h1;
  wire        ck_on = ck[0] & (ck != 5'h01);
  wire        rs = ck_on & (lvds_mode_o ? ck[4] : (ck[2:1] == 2'h3));
  wire        fs = ck_on & (lvds_mode_o ? ck[2] : (ck[4:3] == 2'h3));
  wire [3:0]  hi_exp = 4'h4 + {3'h0, fs} - {3'h0, rs};
  wire [15:0] w_exp = (pat == 3'h1) ? 16'h0000 : (pat == 3'h2) ? 16'hffff :
                      (pat == 3'h5) ? {sh[13], sh[12]} :
                      {conv_q[15] ^ sh[6][3], conv_q[14:0]};

  // Shadow registers; quiet time lets word-latched settings settle first
  always @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i || (reg_wr_i && reg_addr_i == 8'h6e && reg_wdata_i[0]))
    begin
      for (i = 0; i < 18; i = i + 1)
        sh[i] <= (i == 11) ? 8'h09 : 8'h00;
      qcnt <= 5'h00;
      hcnt <= 4'h0;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i >= 8'h5d && reg_addr_i <= 8'h6d)
        sh[reg_addr_i - 8'h5d] <= reg_wdata_i;
      if (reg_wr_i || format_select_pin_i != pin_q || conv_data_i != conv_q)
        qcnt <= 5'h00;
      else if (qcnt != 5'h1f)
        qcnt <= qcnt + 5'h01;
      hcnt <= out_clk_o ? hcnt + 4'h1 : 4'h0;
    end
    pin_q <= format_select_pin_i;
    conv_q <= conv_data_i;
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_bits;
    qcnt == 5'd20 |->
      {low_band_noise_cut_o, low_speed_o, ext_ref_o} == {sh[0][0], sh[6][0], sh[16][4]};
  endproperty
  a_bits: assert property (p_bits)
    else $error("mode bit differs");
  property p_pd;
    qcnt == 5'd20 |-> power_down_o == pd;
  endproperty
  a_pd: assert property (p_pd)
    else $error("power-down flag differs");
  property p_pd_out;
    qcnt == 5'd20 && pd |-> (data_o == 16'h0000 && !out_clk_o) [*8];
  endproperty
  a_pd_out: assert property (p_pd_out)
    else $error("outputs active in power-down");
  property p_gain;
    qcnt == 5'd20 |-> gain_db_o == g_exp;
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain decode differs");
  property p_lvds;
    qcnt == 5'd20 |-> lvds_mode_o == lv;
  endproperty
  a_lvds: assert property (p_lvds)
    else $error("interface choice differs");
  property p_word;
    qcnt == 5'd20 && !pd && pat != 3'h3 && pat != 3'h4 |-> data_o == w_exp;
  endproperty
  a_word: assert property (p_word)
    else $error("output word differs");
  property p_tog;
    qcnt >= 5'd20 && pat == 3'h3 && !pd && $changed(data_o) |->
      data_o == ~$past(data_o) && (data_o == 16'haaaa || data_o == 16'h5555);
  endproperty
  a_tog: assert property (p_tog)
    else $error("toggle word wrong");
  property p_ramp;
    qcnt >= 5'd20 && pat == 3'h4 && !pd && $changed(data_o) |->
      data_o == $past(data_o) + 16'h1;
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("ramp step wrong");
  property p_clk;
    qcnt >= 5'd24 && !pd && $fell(out_clk_o) |-> hcnt == hi_exp;
  endproperty
  a_clk: assert property (p_clk)
    else $error("output clock high time wrong");
endmodule // ccfg_top_props

bind ccfg_top ccfg_top_props ccfg_top_props_i (
  .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .format_select_pin_i(format_select_pin_i),
  .conv_data_i(conv_data_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .data_o(data_o), .out_clk_o(out_clk_o),
  .lvds_mode_o(lvds_mode_o), .low_band_noise_cut_o(low_band_noise_cut_o),
  .low_speed_o(low_speed_o), .power_down_o(power_down_o), .ext_ref_o(ext_ref_o),
  .gain_db_o(gain_db_o)
);

/* File: testbench/ccfg_capture.sv */
`timescale 1ns/1ps
// ****************************************
// Capture logic at the far end of the link
// ****************************************
module ccfg_capture (
  input  wire        clk_i,
  input  wire        out_clk_i,
  input  wire [15:0] data_i,
  output reg  [15:0] word_o,
  output reg  [7:0]  n_o
);
  reg oc_q;
  initial n_o = 8'h00;
  // Take the word on each rising output clock, seen through the local clock
  always @(posedge clk_i)
  begin
    oc_q <= out_clk_i;
    if (out_clk_i && !oc_q)
    begin
      word_o <= data_i;
      n_o <= n_o + 8'h01;
    end
  end
endmodule // ccfg_capture

/* File: testbench/tb_ccfg_top.sv */
`timescale 1ns/1ps
// ****************************************
// Testbench
// ****************************************
module tb_ccfg_top;
  reg         sys_clk_i = 1'b0;
  reg         arst_n_i = 1'b0;
  reg         samp_clk_i = 1'b0;
  reg         pin = 1'b0;
  reg  [15:0] conv = 16'h1234;
  reg         wr = 1'b0;
  reg  [7:0]  addr = 8'h00;
  reg  [7:0]  wdata = 8'h00;
  wire [7:0]  rdata;
  wire [15:0] data;
  wire [15:0] cap;
  wire [7:0]  ncap;
  wire        oclk, lvds, noise, lows, pd, eref;
  wire [2:0]  gdb;
  integer     errors = 0;
  integer     n_checks = 0;
  integer     i;
  integer     j;
  reg  [15:0] w0, w1;
  reg  [39:0] cks = {5'h00, 5'h01, 5'h03, 5'h05, 5'h07, 5'h09, 5'h11, 5'h19};

  ccfg_top ccfg_top_i (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .samp_clk_i(samp_clk_i),
    .format_select_pin_i(pin), .conv_data_i(conv), .reg_wr_i(wr), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .data_o(data), .out_clk_o(oclk),
    .lvds_mode_o(lvds), .low_band_noise_cut_o(noise), .low_speed_o(lows),
    .power_down_o(pd), .ext_ref_o(eref), .gain_db_o(gdb)
  );
  ccfg_capture ccfg_capture_i (
    .clk_i(sys_clk_i), .out_clk_i(oclk), .data_i(data), .word_o(cap), .n_o(ncap)
  );

  // Sample clock free-running at 320 ns, offset in phase from the system clock
  always #20 sys_clk_i = ~sys_clk_i;
  always #160 samp_clk_i = ~samp_clk_i;

  task chk(input [15:0] seen, input [15:0] exp);
  begin
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  end
  endtask
  task waitc(input integer n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task wr8(input [7:0] a, input [7:0] d);
  begin
    @(posedge sys_clk_i);
    #1 wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge sys_clk_i);
    #1 wr = 1'b0;
  end
  endtask
  // Read-back lags the address by one cycle
  task rdchk(input [7:0] a, input [7:0] e);
  begin
    @(posedge sys_clk_i);
    #1 addr = a;
    @(posedge sys_clk_i);
    #1 chk({8'h00, rdata}, {8'h00, e});
  end
  endtask
  // Bounded wait for the capture model to take a new word
  task nextw(output [15:0] w);
    reg [7:0] n0;
    integer   k;
  begin
    n0 = ncap;
    k = 0;
    while (ncap == n0 && k < 40)
    begin
      @(posedge sys_clk_i);
      k = k + 1;
    end
    #1 w = cap;
    // A word that never arrives counts as a mismatch
    chk({15'h0000, ncap != n0}, 16'h0001);
  end
  endtask
  task summarize;
  begin
    $display("checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask

  // Watchdog well beyond the expected run of about 70 us
  initial
  begin
    #400000;
    errors = errors + 1;
    summarize;
  end

  initial
  begin
    waitc(2);
    #1 arst_n_i = 1'b1;
    waitc(4);
    rdchk(8'h62, 8'h00);
    rdchk(8'h68, 8'h09);
    rdchk(8'h6c, 8'h00);
    chk({13'h0000, gdb}, 16'h0001);
    // Host keeps unused bits zero; unmapped place and soft reset
    wr8(8'h63, 8'h89);
    rdchk(8'h63, 8'h89);
    wr8(8'h6c, 8'h18);
    rdchk(8'h6c, 8'h18);
    wr8(8'h70, 8'h5a);
    rdchk(8'h70, 8'h00);
    wr8(8'h68, 8'h0c);
    wr8(8'h6e, 8'h01);
    rdchk(8'h63, 8'h00);
    rdchk(8'h68, 8'h09);
    rdchk(8'h6c, 8'h00);
    $display("test registers done");
    wr8(8'h5d, 8'h01);
    wr8(8'h63, 8'h01);
    wr8(8'h6d, 8'h10);
    waitc(30);
    chk({13'h0000, noise, lows, eref}, 16'h0007);
    wr8(8'h63, 8'h00);
    for (i = 0; i < 15; i = i + 1)
    begin
      wr8(8'h68, i[7:0]);
      waitc(4);
      chk({13'h0000, gdb}, (i > 7) ? i[15:0] - 16'h0008 : 16'h0001);
    end
    $display("test mode bits done");
    for (i = 0; i < 8; i = i + 1)
    begin
      #1 pin = i[0];
      wr8(8'h6c, {3'h0, i[2:1], 3'h0});
      waitc(30);
      w1 = {15'h0000, (i[2:1] == 2'h1 || (i[2:1] != 2'h3 && i[0]))};
      chk({15'h0000, lvds}, w1);
    end
    // Eight clock position codes in both interface modes
    for (j = 0; j < 2; j = j + 1)
      for (i = 0; i < 8; i = i + 1)
      begin
        wr8(8'h6c, j ? 8'h18 : 8'h08);
        wr8(8'h62, {3'h0, cks[i * 5 +: 5]});
        waitc(40);
      end
    wr8(8'h62, 8'h00);
    $display("test interface and clock done");
    wr8(8'h69, 8'h3c);
    wr8(8'h6a, 8'ha5);
    for (i = 0; i < 8; i = i + 1)
      if (i != 3 && i != 4)
      begin
        wr8(8'h65, {i[2:0], 5'h00});
        waitc(40);
        nextw(w0);
        w1 = (i == 1) ? 16'h0000 : (i == 2) ? 16'hffff : (i == 5) ? 16'ha53c : 16'h1234;
        chk(w0, w1);
      end
    wr8(8'h63, 8'h08);
    wr8(8'h65, 8'h00);
    waitc(40);
    nextw(w0);
    chk(w0, 16'h9234);
    // A negative sample shows the sign bit flip the other way
    conv = 16'h8001;
    waitc(40);
    nextw(w0);
    chk(w0, 16'h0001);
    wr8(8'h65, 8'h60);
    waitc(40);
    nextw(w0);
    nextw(w1);
    chk(w1, ~w0);
    chk({15'h0000, w0 == 16'haaaa || w0 == 16'h5555}, 16'h0001);
    wr8(8'h65, 8'h80);
    waitc(40);
    nextw(w0);
    nextw(w1);
    chk(w1, w0 + 16'h0001);
    $display("test patterns done");
    wr8(8'h63, 8'h80);
    waitc(30);
    chk(data, 16'h0000);
    chk({14'h0000, oclk, pd}, 16'h0001);
    wr8(8'h63, 8'h00);
    waitc(30);
    $display("test power-down done");
    summarize;
  end
endmodule // tb_ccfg_top
